/* hw/dpwm_consts.svh */
`ifndef DPWM_CONSTS_SVH
`define DPWM_CONSTS_SVH
// Register map, byte addresses on the plain register port
`define DPWM_ADDR_W 8
`define DPWM_ADDR_CMP0 8'h26
`define DPWM_ADDR_CMP1 8'h27
`define DPWM_ADDR_MODE0 8'h28
`define DPWM_ADDR_MODE1 8'h29
`define DPWM_ADDR_FLOP 8'h2A
`define DPWM_ADDR_RUN 8'h2B
`define DPWM_ADDR_SYSCLK 8'h2C
`define DPWM_ADDR_STAT 8'h2D
// Mode register fields
`define DPWM_MODE_CLK_LSB 0
`define DPWM_MODE_LEN_LSB 2
`define DPWM_MODE_PWM_BIT 4
`define DPWM_MODE_DB_BIT 5
`define DPWM_MODE_IRQ_BIT 6
`define DPWM_MODE_RST 8'h00
// Flop control: bits 1:0 ch0 trigger, 3:2 ch1 trigger, 4 ch0 invert en, 5 ch1 invert en
`define DPWM_FLOP_RST 8'h00
`define DPWM_FLOP_INV_LSB 4
// Run register: bit0 ch0, bit1 ch1, bit7 prescaler run
`define DPWM_RUN_PRE_BIT 7
`define DPWM_RUN_RST 8'h00
// Source select in bits 1:0 of the clock control register
`define DPWM_SRC_RST 2'h0
`define DPWM_SRC_GEAR 2'h0
`define DPWM_SRC_LOWF 2'h1
`define DPWM_SRC_FC16 2'h2
// Trigger encodings
`define DPWM_TRG_CLR_OVF 2'h2
`define DPWM_TRG_SET_OVF 2'h3
// Cycle length codes
`define DPWM_LEN_6 2'h1
`define DPWM_LEN_7 2'h2
`define DPWM_LEN_8 2'h3
`define DPWM_PRE_W 5
`endif

/* hw/dpwm_pkg.sv */
package dpwm_pkg;
	typedef logic [7:0] dpwm_byte_t;
	typedef struct packed {
		logic [7:0] cnt;
		logic [7:0] active;
		logic [7:0] buffer;
		logic [7:0] mode;
		logic flop;
		logic irq;
	} dpwm_chan_s;
	typedef struct packed {
		dpwm_chan_s [1:0] ch;
		logic [7:0] flop_ctrl;
		logic [7:0] run;
		logic [1:0] src_sel;
		logic half;
		logic [4:0] pre;
		logic [4:0] pre_prev;
		logic [2:0] src_sync1;
		logic [2:0] src_sync2;
		logic src_prev;
		logic [7:0] rdata;
	} dpwm_state_s;
endpackage

/* hw/dpwm_timer.sv */
`timescale 1ns/1ps
`include "dpwm_consts.svh"
// Summary of operation
// R1: Two independent channels, each with counter, comparator, compare register, output flop.
// R2: One shared 5-bit prescaler gives three taps; each channel picks one or the halved source.
// R3: Source select 00 gear clock, 01 low-frequency, 10 fc/16; halved first.
// R4: Taps divide the selected source by four, sixteen and sixty-four.
// R5: Reset loads source select with 00.
// R6: Software must not pick fc/16 while low-frequency clock is the system clock.
// R7: Prescaler run bit counts at 1; writing 0 clears and stops it; reset clears.
// R8: Software should clear prescaler run before oscillator-only idle halt.
// R9: Each counter increments on the tap its clock select chooses.
// R10: Mode bit resets to 0 for PWM; 1 selects interval timer.
// R11: PWM clears counter on 2^n-1 overflow; interval mode clears on match.
// R12: Channel run bit starts counting; clearing stops and clears counter; reset stops all.
// R13: Match asserts when counter equals active compare value.
// R14: Double-buffer enable bit, 0 off, 1 on, resets to 0.
// R15: Buffered: active loads buffer on overflow in PWM or match in interval mode.
// R16: Write updates buffer and active unbuffered; buffer only when buffered.
// R17: Compare address reads buffer; active register is never readable.
// R18: Channel 0 compare at 26h, channel 1 at 27h, one shared address each.
// R19: Software writes initial value, enables buffering, then writes next value.
// R20: Match raises channel interrupt when its interrupt select bit is 1.
// R21: Output flop changes on match or overflow when enabled; drives output pin.
// R22: Interval mode is allowed with double buffering on.
// R23: PWM cycle 2^n-1 counts, n 6/7/8; overflow beats simultaneous match.
// R24: Trigger 10 clears on overflow, sets on match; 11 the reverse.
// R25: Mode register length field picks n; overflow fires at 2^n-1.
module dpwm_timer (
	input wire logic clock,
	input wire logic rst,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr_en,
	input wire logic rd_en,
	input wire logic gear_divided_clock,
	input wire logic low_freq_clock,
	input wire logic fc16_clock,
	output logic [7:0] rdata,
	output logic timer_out_pin_ch0,
	output logic timer_out_pin_ch1,
	output logic match_irq_ch0,
	output logic match_irq_ch1
);
	// Whole block state, registered once per clock
	dpwm_pkg::dpwm_state_s state_ff;
	dpwm_pkg::dpwm_state_s nxt_state;

	// Full-cycle value 2^n-1 for a length code
	// Code 00 is taken as n of 8 so that no code leaves the counter unbounded
	function automatic logic [7:0] top_of(input logic [1:0] len);
		case (len)
			`DPWM_LEN_6: begin
				top_of = 8'h3F;
			end
			`DPWM_LEN_7: begin
				top_of = 8'h7F;
			end
			default: begin
				top_of = 8'hFF;
			end
		endcase
	endfunction

	// Counter value from which the next tap reaches 2^n-1
	// The counter clears instead of holding 2^n-1, so one cycle is 2^n-1 taps, not 2^n
	function automatic logic [7:0] last_of(input logic [1:0] len);
		case (len)
			`DPWM_LEN_6: begin
				last_of = 8'h3E;
			end
			`DPWM_LEN_7: begin
				last_of = 8'h7E;
			end
			default: begin
				last_of = 8'hFE;
			end
		endcase
	endfunction

	// Counting pulse for a channel clock select
	// Select 00 takes the halved source itself; 01, 10, 11 take the prescaler taps
	// Prescaler bits 0, 2 and 4 rise every 4, 16 and 64 source rises
	function automatic logic tap_rise(input logic [1:0] sel, input logic [4:0] cur,
		input logic [4:0] prev, input logic half_rise);
		case (sel)
			2'h0: begin
				tap_rise = half_rise;
			end
			2'h1: begin
				tap_rise = cur[0] & ~prev[0];
			end
			2'h2: begin
				tap_rise = cur[2] & ~prev[2];
			end
			default: begin
				tap_rise = cur[4] & ~prev[4];
			end
		endcase
	endfunction

	// Source clock path
	logic src_lvl;
	logic src_rise;
	logic half_rise;

	// Per-channel decode of the mode, flop control and run registers
	logic [1:0] clk_sel [0:1];
	logic [1:0] len_sel [0:1];
	logic [1:0] trigger [0:1];
	logic [1:0] interval;
	logic [1:0] buffered;
	logic [1:0] irq_sel;
	logic [1:0] invert_en;
	logic [1:0] running;

	// Per-channel events, valid only together with a tick
	logic [1:0] tick;
	logic [1:0] hit_ovf;
	logic [1:0] hit_match;
	logic [1:0] cycle_end;
	logic [1:0] counting;

	// Next-state logic for the whole block
	always_comb begin
		nxt_state = state_ff;

		// Source clocks come from other domains; two flops each, only the second stage is read
		nxt_state.src_sync1 = {fc16_clock, low_freq_clock, gear_divided_clock};
		nxt_state.src_sync2 = state_ff.src_sync1;

		// Source select picks one synchronised level
		case (state_ff.src_sel) // R3
			`DPWM_SRC_GEAR: begin
				src_lvl = state_ff.src_sync2[0];
			end
			`DPWM_SRC_LOWF: begin
				src_lvl = state_ff.src_sync2[1];
			end
			default: begin
				src_lvl = state_ff.src_sync2[2]; // R6
			end
		endcase

		// Edge detect on the selected level; a select change may cost one stray edge
		src_rise = src_lvl & ~state_ff.src_prev;
		nxt_state.src_prev = src_lvl;

		// Halve then count; the taps then divide the source by 4, 16, 64
		half_rise = 1'b0;
		nxt_state.pre_prev = state_ff.pre;
		if (state_ff.run[`DPWM_RUN_PRE_BIT]) begin // R7
			if (src_rise) begin
				nxt_state.half = ~state_ff.half; // R3
				half_rise = ~state_ff.half;
				if (state_ff.half) begin
					nxt_state.pre = state_ff.pre + 5'h01; // R2 R4
				end
			end
		end else begin
			// Stopped prescaler is held clear so a restart begins from a known phase
			nxt_state.half = 1'b0; // R7
			nxt_state.pre = 5'h00;
			nxt_state.pre_prev = 5'h00;
		end

		// Field decode, one copy per channel
		for (int i = 0; i < 2; i++) begin
			clk_sel[i] = state_ff.ch[i].mode[`DPWM_MODE_CLK_LSB +: 2];
			len_sel[i] = state_ff.ch[i].mode[`DPWM_MODE_LEN_LSB +: 2]; // R25
			interval[i] = state_ff.ch[i].mode[`DPWM_MODE_PWM_BIT]; // R10
			buffered[i] = state_ff.ch[i].mode[`DPWM_MODE_DB_BIT]; // R14
			irq_sel[i] = state_ff.ch[i].mode[`DPWM_MODE_IRQ_BIT];
			trigger[i] = state_ff.flop_ctrl[2*i +: 2];
			invert_en[i] = state_ff.flop_ctrl[`DPWM_FLOP_INV_LSB + i];
			running[i] = state_ff.run[i]; // R12
		end

		// Tap choice and compare events
		for (int i = 0; i < 2; i++) begin
			tick[i] = tap_rise(clk_sel[i], state_ff.pre, state_ff.pre_prev, half_rise); // R9
			counting[i] = running[i] & tick[i];
			// Overflow exists only in PWM mode
			hit_ovf[i] = ~interval[i] & (state_ff.ch[i].cnt == last_of(len_sel[i])); // R23 R25
			// A compare of 2^n-1 is reached on the overflow tap itself
			hit_match[i] = (state_ff.ch[i].cnt == state_ff.ch[i].active) |
				(hit_ovf[i] & (state_ff.ch[i].active == top_of(len_sel[i]))); // R13
			// Overflow ends a PWM cycle, a match ends an interval
			cycle_end[i] = hit_ovf[i] | (interval[i] & hit_match[i]); // R11
		end

		// Up counters
		for (int i = 0; i < 2; i++) begin
			if (!running[i]) begin
				nxt_state.ch[i].cnt = 8'h00; // R12
			end else if (tick[i]) begin
				if (cycle_end[i]) begin
					nxt_state.ch[i].cnt = 8'h00; // R11
				end else begin
					nxt_state.ch[i].cnt = state_ff.ch[i].cnt + 8'h01; // R9
				end
			end
		end

		// Buffer copy on the event that ends each cycle, in either mode
		for (int i = 0; i < 2; i++) begin
			if (counting[i] && buffered[i] && cycle_end[i]) begin
				nxt_state.ch[i].active = state_ff.ch[i].buffer; // R15 R22
			end
		end

		// Match interrupt, a one-cycle pulse per counted match
		for (int i = 0; i < 2; i++) begin
			nxt_state.ch[i].irq = counting[i] & hit_match[i] & irq_sel[i]; // R20
		end

		// Output flops; overflow is looked at first so 0% and 100% duty are reachable
		for (int i = 0; i < 2; i++) begin
			if (counting[i]) begin
				if (hit_ovf[i]) begin
					// Trigger 0x leaves the flop alone in PWM mode
					if (trigger[i][1]) begin
						nxt_state.ch[i].flop = trigger[i][0]; // R23 R24
					end
				end else if (hit_match[i]) begin
					if (interval[i]) begin
						if (invert_en[i]) begin
							nxt_state.ch[i].flop = ~state_ff.ch[i].flop; // R21
						end
					end else if (trigger[i][1]) begin
						nxt_state.ch[i].flop = ~trigger[i][0]; // R24
					end
				end
			end
		end

		// Register writes; a write lands after the counting events of the same cycle
		if (wr_en) begin
			case (addr)
				`DPWM_ADDR_CMP0, `DPWM_ADDR_CMP1: begin
					nxt_state.ch[addr[0]].buffer = wdata; // R16 R18
					if (!state_ff.ch[addr[0]].mode[`DPWM_MODE_DB_BIT]) begin
						nxt_state.ch[addr[0]].active = wdata; // R16
					end
				end
				`DPWM_ADDR_MODE0: begin
					nxt_state.ch[0].mode = wdata; // R10 R14
				end
				`DPWM_ADDR_MODE1: begin
					nxt_state.ch[1].mode = wdata;
				end
				`DPWM_ADDR_FLOP: begin
					nxt_state.flop_ctrl = wdata;
				end
				`DPWM_ADDR_RUN: begin
					nxt_state.run = wdata; // R7 R12
				end
				`DPWM_ADDR_SYSCLK: begin
					nxt_state.src_sel = wdata[1:0]; // R3
				end
				default: begin
					// Unmapped writes are dropped
				end
			endcase
		end

		// Register reads, data valid the cycle after the strobe and zero otherwise
		nxt_state.rdata = 8'h00;
		if (rd_en) begin
			case (addr)
				`DPWM_ADDR_CMP0: begin
					nxt_state.rdata = state_ff.ch[0].buffer; // R17
				end
				`DPWM_ADDR_CMP1: begin
					nxt_state.rdata = state_ff.ch[1].buffer; // R17
				end
				`DPWM_ADDR_MODE0: begin
					nxt_state.rdata = state_ff.ch[0].mode;
				end
				`DPWM_ADDR_MODE1: begin
					nxt_state.rdata = state_ff.ch[1].mode;
				end
				`DPWM_ADDR_FLOP: begin
					nxt_state.rdata = state_ff.flop_ctrl;
				end
				`DPWM_ADDR_RUN: begin
					nxt_state.rdata = state_ff.run;
				end
				`DPWM_ADDR_SYSCLK: begin
					nxt_state.rdata = {6'h00, state_ff.src_sel};
				end
				`DPWM_ADDR_STAT: begin
					// Flop levels, so software can see a pin it has not routed out
					nxt_state.rdata = {6'h00, state_ff.ch[1].flop, state_ff.ch[0].flop};
				end
				default: begin
					nxt_state.rdata = 8'h00;
				end
			endcase
		end
	end

	// State register; compare values are cleared too so a read after reset is defined
	// The synchroniser stages are left out of reset, they refill within two clocks
	always_ff @(posedge clock) begin
		state_ff <= nxt_state;
		if (rst) begin
			state_ff.src_sel <= `DPWM_SRC_RST; // R5
			state_ff.run <= `DPWM_RUN_RST; // R7 R12
			state_ff.flop_ctrl <= `DPWM_FLOP_RST;
			state_ff.half <= 1'b0;
			state_ff.pre <= 5'h00;
			state_ff.pre_prev <= 5'h00;
			state_ff.rdata <= 8'h00;
			state_ff.ch[0].cnt <= 8'h00;
			state_ff.ch[1].cnt <= 8'h00;
			state_ff.ch[0].mode <= `DPWM_MODE_RST; // R10 R14
			state_ff.ch[1].mode <= `DPWM_MODE_RST;
			state_ff.ch[0].flop <= 1'b0;
			state_ff.ch[1].flop <= 1'b0;
			state_ff.ch[0].irq <= 1'b0;
			state_ff.ch[1].irq <= 1'b0;
			state_ff.ch[0].active <= 8'h00;
			state_ff.ch[1].active <= 8'h00;
			state_ff.ch[0].buffer <= 8'h00;
			state_ff.ch[1].buffer <= 8'h00;
		end
	end


	// Outputs straight from the state flops
	assign rdata = state_ff.rdata;

	// Pins carry the flop levels with no further logic
	assign timer_out_pin_ch0 = state_ff.ch[0].flop; // R21
	assign timer_out_pin_ch1 = state_ff.ch[1].flop; // R1

	// Interrupt pulses, one cycle each
	assign match_irq_ch0 = state_ff.ch[0].irq; // R20
	assign match_irq_ch1 = state_ff.ch[1].irq;
endmodule // dpwm_timer

/* tb/dpwm_timer_assertions.sv */
`timescale 1ns/1ps
`include "dpwm_consts.svh"
module dpwm_checker (
	input logic clock,
	input logic rst,
	input logic [7:0] addr,
	input logic [7:0] wdata,
	input logic wr_en,
	input logic rd_en,
	input logic [7:0] rdata,
	input logic timer_out_pin_ch0,
	input logic timer_out_pin_ch1,
	input logic match_irq_ch0,
	input logic match_irq_ch1
);
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	// Write, idle cycle, read of the same compare address
	sequence s_wr_rd(a);
		wr_en && addr == a ##2 rd_en && addr == a;
	endsequence
	a_rd_idle: assert property (!$past(rd_en) |-> rdata == 8'h00)
		else $error("read data not idle");
	a_reset_quiet: assert property ($past(rst) |-> !(timer_out_pin_ch0 || timer_out_pin_ch1
		|| match_irq_ch0 || match_irq_ch1)) else $error("outputs active after reset");
	a_cmp0_back: assert property (s_wr_rd(`DPWM_ADDR_CMP0) |=> rdata == $past(wdata, 3))
		else $error("compare ch0 read back wrong");
	a_cmp1_back: assert property (s_wr_rd(`DPWM_ADDR_CMP1) |=> rdata == $past(wdata, 3))
		else $error("compare ch1 read back wrong");
	a_unmapped_zero: assert property (rd_en && addr > 8'h2D |=> rdata == 8'h00)
		else $error("unmapped read not zero");
	a_irq0_pulse: assert property (match_irq_ch0 |=> !match_irq_ch0)
		else $error("ch0 interrupt longer than one cycle");
	a_irq1_pulse: assert property (match_irq_ch1 |=> !match_irq_ch1)
		else $error("ch1 interrupt longer than one cycle");
	// Stopped channels must go quiet once the write has settled
	a_stop_quiet: assert property (wr_en && addr == `DPWM_ADDR_RUN && wdata == 8'h00
		|-> ##3 (!match_irq_ch0 && !match_irq_ch1) [*8]) else $error("interrupt while stopped");
endmodule // dpwm_checker
bind dpwm_timer dpwm_checker u_chk (.clock(clock), .rst(rst), .addr(addr), .wdata(wdata),
	.wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .timer_out_pin_ch0(timer_out_pin_ch0),
	.timer_out_pin_ch1(timer_out_pin_ch1), .match_irq_ch0(match_irq_ch0),
	.match_irq_ch1(match_irq_ch1));

/* tb/testbench.sv */
`timescale 1ns/1ps
`include "dpwm_consts.svh"
module testbench;
	logic clock, rst, wr_en, rd_en, src_g, src_l, src_f, pin0, pin1, irq0, irq1;
	logic [7:0] addr, wdata, rdata, d;
	int fails, checks_done, i, n, g, bad, k;
	dpwm_timer dut (.clock(clock), .rst(rst), .addr(addr), .wdata(wdata), .wr_en(wr_en),
		.rd_en(rd_en), .gear_divided_clock(src_g), .low_freq_clock(src_l), .fc16_clock(src_f),
		.rdata(rdata), .timer_out_pin_ch0(pin0), .timer_out_pin_ch1(pin1),
		.match_irq_ch0(irq0), .match_irq_ch1(irq1));
	// System clock
	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end
	// Sources of 8, 16 and 24 clocks, offset so edges never meet the clock edge
	initial begin
		{src_g, src_l, src_f} = 3'h0;
		k = 0;
		#3;
		forever begin
			#32;
			k++;
			src_g = ~src_g;
			if (k % 2 == 0) src_l = ~src_l;
			if (k % 3 == 0) src_f = ~src_f;
		end
	end
	task automatic finish_test();
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] e, input logic [31:0] s);
		checks_done++;
		if (s !== e) begin
			fails++;
			$display("MISMATCH %s expected %0d seen %0d", what, e, s);
		end
	endtask
	// Bus cycles keep one idle cycle so a strobe is never assigned twice in a step
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		addr <= a;
		wdata <= v;
		wr_en <= 1'b1;
		@(posedge clock);
		wr_en <= 1'b0;
		@(posedge clock);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge clock);
		rd_en <= 1'b0;
		#1 chk("rdata", 32'(e), 32'(rdata));
		@(posedge clock);
	endtask
	// Clocks until the next interrupt pulse, bounded
	task automatic meas(output int c);
		for (c = 1; c < 20000; c++) begin
			@(posedge clock);
			#1;
			if (irq0 === 1'b1 || irq1 === 1'b1)
				return;
		end
		fails++;
		finish_test();
	endtask
	initial begin
		void'($urandom(32'hB1077633));
		rst = 1'b1;
		{wr_en, rd_en, addr, wdata} = '0;
		fails = 0;
		checks_done = 0;
		repeat (5) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		rd(`DPWM_ADDR_CMP1, 8'h00);
		wr(8'h3F, 8'($urandom));
		rd(8'h3F, 8'h00);
		for (i = 0; i < 2; i++) begin
			d = 8'($urandom);
			wr(`DPWM_ADDR_CMP0 + 8'(i), d);
			rd(`DPWM_ADDR_CMP0 + 8'(i), d);
		end
		// Interval mode: every clock select, sources in turn; period is compare+1 taps
		for (i = 0; i < 4; i++) begin
			n = 1 + $urandom % 3;
			wr(`DPWM_ADDR_RUN, 8'h00);
			wr(`DPWM_ADDR_SYSCLK, 8'(i % 3));
			wr(`DPWM_ADDR_MODE0, 8'h50 + 8'(i));
			wr(`DPWM_ADDR_CMP0, 8'(n));
			wr(`DPWM_ADDR_RUN, 8'h81);
			meas(g);
			meas(g);
			k = (i == 0) ? 2 : (1 << (2 * i));
			chk("interval", (n + 1) * k * 8 * ((i % 3) + 1), g);
		end
		// Buffered write waits for the next match before it takes hold
		wr(`DPWM_ADDR_RUN, 8'h00);
		wr(`DPWM_ADDR_SYSCLK, 8'h00);
		wr(`DPWM_ADDR_MODE0, 8'h51);
		wr(`DPWM_ADDR_CMP0, 8'h03);
		wr(`DPWM_ADDR_MODE0, 8'h71);
		wr(`DPWM_ADDR_FLOP, 8'h10);
		wr(`DPWM_ADDR_RUN, 8'h81);
		meas(g);
		d = {7'h00, pin0};
		wr(`DPWM_ADDR_CMP0, 8'h06);
		meas(g);
		chk("old interval", 126, g);
		chk("toggle pin", 32'(!d[0]), 32'(pin0));
		meas(g);
		chk("new interval", 224, g);
		rd(`DPWM_ADDR_CMP0, 8'h06);
		// Channel 1 PWM: one match per 2^n-1 taps for length codes 01, 10 and 11
		wr(`DPWM_ADDR_FLOP, 8'h08);
		wr(`DPWM_ADDR_CMP1, 8'h0A);
		for (i = 1; i < 4; i++) begin
			wr(`DPWM_ADDR_RUN, 8'h00);
			wr(`DPWM_ADDR_MODE1, 8'h41 + 8'(i << 2));
			wr(`DPWM_ADDR_RUN, 8'h82);
			meas(g);
			meas(g);
			chk("pwm cycle", ((1 << (i + 5)) - 1) * 32, g);
		end
		// Compare at 2^6-1: overflow wins, so the pin holds its overflow level
		wr(`DPWM_ADDR_RUN, 8'h00);
		wr(`DPWM_ADDR_MODE1, 8'h05);
		wr(`DPWM_ADDR_CMP1, 8'h3F);
		wr(`DPWM_ADDR_RUN, 8'h82);
		for (i = 0; i < 2; i++) begin
			wr(`DPWM_ADDR_FLOP, 8'h08 + 8'(i << 2));
			repeat (2200) @(posedge clock);
			bad = 0;
			repeat (2100) begin
				@(posedge clock);
				#1;
				bad += int'(pin1 !== 1'(i));
			end
			chk("duty pin", 0, bad);
		end
		finish_test();
	end
endmodule // testbench
